// *** inc/spcr_map.svh ***
// Index map, field positions, reset values and write masks of the serial port config bank
`ifndef SPCR_MAP_SVH
`define SPCR_MAP_SVH

// ----------------------------------------------------------------------
// Configuration indexes (byte address = 4 * index, port on address bit 10)
// ----------------------------------------------------------------------
`define SPCR_IDX_ACTIVATE   8'h30
`define SPCR_IDX_BASE_HIGH  8'h60
`define SPCR_IDX_BASE_LOW   8'h61
`define SPCR_IDX_IRQ_NUMBER 8'h70
`define SPCR_IDX_IRQ_TYPE   8'h71
`define SPCR_IDX_DMA_0      8'h74
`define SPCR_IDX_DMA_1      8'h75
`define SPCR_IDX_PORT_CFG   8'hf0
`define SPCR_IDX_GLOBAL     8'h20
`define SPCR_PORT_SEL_BIT   10

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SPCR_RST_ACTIVATE    8'h00
`define SPCR_RST_A_BASE_HIGH 8'h03
`define SPCR_RST_B_BASE_HIGH 8'h02
`define SPCR_RST_BASE_LOW    8'hf8
`define SPCR_RST_A_IRQ_NUM   8'h04
`define SPCR_RST_B_IRQ_NUM   8'h03
`define SPCR_RST_IRQ_TYPE    8'h03
`define SPCR_RST_DMA         8'h04
`define SPCR_RST_PORT_CFG    8'h02
`define SPCR_RST_GLOBAL      8'h0d

// ----------------------------------------------------------------------
// Field positions and writable-bit masks
// ----------------------------------------------------------------------
`define SPCR_CFG_BANK_EN   7
`define SPCR_CFG_BUSY      2
`define SPCR_CFG_PWR_MODE  1
`define SPCR_CFG_FLOAT_EN  0
`define SPCR_ACT_BIT       0
`define SPCR_GLB_ENABLE    0
`define SPCR_GLB_B_ENABLE  2
`define SPCR_GLB_A_ENABLE  3
`define SPCR_WR_ACTIVATE   8'h01
`define SPCR_WR_BASE_HIGH  8'h07
`define SPCR_WR_BASE_LOW   8'hf8
`define SPCR_WR_IRQ_TYPE   8'h02
`define SPCR_WR_PORT_CFG   8'h83
`define SPCR_WR_GLOBAL     8'h0d

`endif

// *** inc/spcr_pkg.sv ***
// Types shared by the serial port configuration bank and its users
package spcr_pkg;

    // Stored bytes of one port's configuration set
    typedef struct packed {
        logic [7:0] activate;
        logic [7:0] base_high;
        logic [7:0] base_low;
        logic [7:0] irq_number;
        logic [7:0] irq_type;
        logic [7:0] dma_rx;
        logic [7:0] dma_tx;
        logic [7:0] port_cfg;
    } spcr_port_regs_s;

    // Status coming from the port's own core, same clock
    typedef struct packed {
        logic busy;
        logic uart_irq;
        logic ring_irq_en;
    } spcr_core_stat_s;

    // Control handed to the port's core and pin logic
    typedef struct packed {
        logic        active;
        logic        clk_en;
        logic        outputs_default;
        logic        outputs_float;
        logic        runtime_en;
        logic        ext_en;
        logic        irq;
        logic [15:0] base_addr;
        logic [7:0]  irq_number;
        logic [7:0]  irq_type;
        logic [7:0]  dma_rx;
        logic [7:0]  dma_tx;
    } spcr_port_ctl_s;

    // Bus slave sequencing
    typedef enum logic [0:0] {
        SPCR_IDLE,
        SPCR_ACK
    } spcr_bus_e;

endpackage

// *** design/spcr_regs.sv ***
// Configuration register bank for two serial ports behind a classic Wishbone slave
// How it works
// - Base high byte bits 7..3 always read zero; writes there are dropped.
// - Base low byte bits 2..0 always read zero, base is eight-byte aligned.
// - Interrupt type accepts writes on bit 1 only; resets to 03h.
// - Port B has writable receive and transmit DMA selects, both resetting 04h.
// - Port A DMA registers are read-only and always report 04h.
// - Port B resets: config 02h, base 02h/F8h, interrupt number 03h.
// - Port A resets: config 02h, base 03h/F8h, interrupt number 04h.
// - Extended register access is blocked until bank enable bit 7 is set.
// - Config bit 2 is read-only busy, one during transfer, zero otherwise.
// - Power bit zero on active port stops clock, outputs default, keeps registers.
// - In low power the ring indicator can still raise the port interrupt.
// - Power bit one runs the clock; port fully works while active.
// - Deactivating the port also blocks runtime register access.
// - Float bit one with port inactive floats the output pins; resets zero.
// - Infrared transmit is driven low whenever port B is inactive.
// - Activate resets 00h and is gated by global enable and per-port enable.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"

module spcr_regs
    import spcr_pkg::*;
#(
    parameter int WB_ADR_W = 11
)
(
    input  wire logic                  clock_in,
    input  wire logic                  resetn_in,
    // Wishbone classic slave
    input  wire logic                  wb_cyc_in,
    input  wire logic                  wb_stb_in,
    input  wire logic                  wb_we_in,
    input  wire logic [WB_ADR_W-1:0]   wb_adr_in,
    input  wire logic [3:0]            wb_sel_in,
    input  wire logic [31:0]           wb_dat_in,
    output logic      [31:0]           wb_dat_out,
    output logic                       wb_ack_out,
    // Port cores, same clock
    input  wire spcr_core_stat_s       uart_a_stat_in,
    input  wire spcr_core_stat_s       uart_b_stat_in,
    input  wire logic                  uart_b_ir_tx_in,
    // Ring indicator pins, active low, asynchronous
    input  wire logic                  uart_a_ring_n_in,
    input  wire logic                  uart_b_ring_n_in,
    // Control towards the ports
    output spcr_port_ctl_s             uart_a_ctl_out,
    output spcr_port_ctl_s             uart_b_ctl_out,
    output logic                       infrared_transmit_out
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    // Index bits 9..2 plus the port select bit must all be present
    if (WB_ADR_W < `SPCR_PORT_SEL_BIT + 1)
    begin : g_adr_check
        $error("spcr_regs: WB_ADR_W too small for the index map");
    end

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    // Merge write data into only the bits that software may change
    function automatic logic [7:0] masked_write(
        input logic [7:0] old_val,
        input logic [7:0] wr_val,
        input logic [7:0] mask
    );
        masked_write = (old_val & ~mask) | (wr_val & mask);
    endfunction

    // Reset image of one port; index 0 is port A, 1 is port B
    function automatic spcr_port_regs_s reset_image(input logic is_b);
        spcr_port_regs_s r;
        r.activate   = `SPCR_RST_ACTIVATE;
        r.base_high  = is_b ? `SPCR_RST_B_BASE_HIGH : `SPCR_RST_A_BASE_HIGH;
        r.base_low   = `SPCR_RST_BASE_LOW;
        r.irq_number = is_b ? `SPCR_RST_B_IRQ_NUM : `SPCR_RST_A_IRQ_NUM;
        r.irq_type   = `SPCR_RST_IRQ_TYPE;
        r.dma_rx     = `SPCR_RST_DMA;
        r.dma_tx     = `SPCR_RST_DMA;
        r.port_cfg   = `SPCR_RST_PORT_CFG;
        reset_image  = r;
    endfunction

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Decoded request, index and port of the current bus cycle
    logic        req;
    logic        wr_req;
    logic [7:0]  idx;
    logic        port_sel;
    logic [7:0]  wr_byte;
    logic        ack_q;

    // New request only when no ack is pending, so each cycle is taken once
    assign req      = wb_cyc_in && wb_stb_in && !ack_q;
    assign wr_req   = req && wb_we_in && wb_sel_in[0];
    assign idx      = wb_adr_in[9:2];
    assign port_sel = wb_adr_in[`SPCR_PORT_SEL_BIT];
    assign wr_byte  = wb_dat_in[7:0];

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    // Index 0 holds port A, index 1 port B
    spcr_port_regs_s regs_q [2];
    logic [7:0]      global_q;

    // Global enables shared by both ports
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            global_q <= `SPCR_RST_GLOBAL;
        end
        else if (wr_req && idx == `SPCR_IDX_GLOBAL)
        begin
            global_q <= masked_write(global_q, wr_byte, `SPCR_WR_GLOBAL);
        end
    end

    // Per-port configuration bytes; writes land at the taking edge
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            regs_q[0] <= reset_image(1'b0);
            regs_q[1] <= reset_image(1'b1);
        end
        else if (wr_req)
        begin
            // Only the addressed port's set takes the write
            for (int p = 0; p < 2; p++)
            begin
                if (port_sel == p[0])
                begin
                    if (idx == `SPCR_IDX_ACTIVATE)
                    begin
                        regs_q[p].activate <= masked_write(regs_q[p].activate,
                            wr_byte, `SPCR_WR_ACTIVATE);
                    end
                    else if (idx == `SPCR_IDX_BASE_HIGH)
                    begin
                        regs_q[p].base_high <= masked_write(regs_q[p].base_high,
                            wr_byte, `SPCR_WR_BASE_HIGH);
                    end
                    else if (idx == `SPCR_IDX_BASE_LOW)
                    begin
                        regs_q[p].base_low <= masked_write(regs_q[p].base_low,
                            wr_byte, `SPCR_WR_BASE_LOW);
                    end
                    else if (idx == `SPCR_IDX_IRQ_NUMBER)
                    begin
                        regs_q[p].irq_number <= wr_byte;
                    end
                    else if (idx == `SPCR_IDX_IRQ_TYPE)
                    begin
                        regs_q[p].irq_type <= masked_write(regs_q[p].irq_type,
                            wr_byte, `SPCR_WR_IRQ_TYPE);
                    end
                    else if (idx == `SPCR_IDX_DMA_0 && p == 1)
                    begin
                        regs_q[p].dma_rx <= wr_byte;
                    end
                    else if (idx == `SPCR_IDX_DMA_1 && p == 1)
                    begin
                        regs_q[p].dma_tx <= wr_byte;
                    end
                    else if (idx == `SPCR_IDX_PORT_CFG)
                    begin
                        regs_q[p].port_cfg <= masked_write(regs_q[p].port_cfg,
                            wr_byte, `SPCR_WR_PORT_CFG);
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Selected port's bytes and its live busy level
    logic [7:0]      rd_byte;
    spcr_port_regs_s rd_regs;
    logic            rd_busy;

    // Port A's DMA bytes never change, so they report "no channel" for good
    always_comb
    begin
        rd_regs = port_sel ? regs_q[1] : regs_q[0];
        rd_busy = port_sel ? uart_b_stat_in.busy : uart_a_stat_in.busy;
        rd_byte = 8'h00;
        if (idx == `SPCR_IDX_ACTIVATE)
        begin
            rd_byte = rd_regs.activate;
        end
        else if (idx == `SPCR_IDX_BASE_HIGH)
        begin
            rd_byte = rd_regs.base_high & `SPCR_WR_BASE_HIGH;
        end
        else if (idx == `SPCR_IDX_BASE_LOW)
        begin
            rd_byte = rd_regs.base_low & `SPCR_WR_BASE_LOW;
        end
        else if (idx == `SPCR_IDX_IRQ_NUMBER)
        begin
            rd_byte = rd_regs.irq_number;
        end
        else if (idx == `SPCR_IDX_IRQ_TYPE)
        begin
            rd_byte = rd_regs.irq_type;
        end
        else if (idx == `SPCR_IDX_DMA_0)
        begin
            rd_byte = rd_regs.dma_rx;
        end
        else if (idx == `SPCR_IDX_DMA_1)
        begin
            rd_byte = rd_regs.dma_tx;
        end
        else if (idx == `SPCR_IDX_PORT_CFG)
        begin
            rd_byte = rd_regs.port_cfg & `SPCR_WR_PORT_CFG;
            rd_byte[`SPCR_CFG_BUSY] = rd_busy;
        end
        else if (idx == `SPCR_IDX_GLOBAL)
        begin
            rd_byte = global_q;
        end
    end

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    // One wait state; unmapped indexes still ack and read zero
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= req;
        end
    end

    // Read data captured with the request and held while ack stands
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            wb_dat_out <= 32'h0000_0000;
        end
        else if (req)
        begin
            wb_dat_out <= {24'h00_0000, wb_we_in ? 8'h00 : rd_byte};
        end
    end

    // Ack straight from its flop, so it never glitches
    assign wb_ack_out = ack_q;

    // ------------------------------------------------------------------
    // Ring indicator synchronisers
    // ------------------------------------------------------------------
    // Bit 0 serves port A, bit 1 port B
    logic [1:0] ring_meta_q;
    logic [1:0] ring_n_q;

    // Pins are asynchronous; second stage is the only reader of the first
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            ring_meta_q <= 2'b11;
            ring_n_q    <= 2'b11;
        end
        else
        begin
            ring_meta_q <= {uart_b_ring_n_in, uart_a_ring_n_in};
            ring_n_q    <= ring_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Port control derivation
    // ------------------------------------------------------------------
    // Next control values, indexed like the register sets
    spcr_port_ctl_s  ctl_d [2];
    spcr_core_stat_s stat  [2];
    logic [1:0]      port_enable;

    // Array views so one loop serves both ports
    assign stat[0] = uart_a_stat_in;
    assign stat[1] = uart_b_stat_in;
    assign port_enable[0] = global_q[`SPCR_GLB_A_ENABLE];
    assign port_enable[1] = global_q[`SPCR_GLB_B_ENABLE];

    // Power and float decisions per port, all from stored bytes
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            ctl_d[p].active = regs_q[p].activate[`SPCR_ACT_BIT]
                && global_q[`SPCR_GLB_ENABLE] && port_enable[p];
            ctl_d[p].clk_en = ctl_d[p].active
                && regs_q[p].port_cfg[`SPCR_CFG_PWR_MODE];
            ctl_d[p].outputs_default = ctl_d[p].active
                && !regs_q[p].port_cfg[`SPCR_CFG_PWR_MODE];
            ctl_d[p].outputs_float = !ctl_d[p].active
                && regs_q[p].port_cfg[`SPCR_CFG_FLOAT_EN];
            // Low power keeps runtime access; only deactivation removes it
            ctl_d[p].runtime_en = ctl_d[p].active;
            ctl_d[p].ext_en = ctl_d[p].active
                && regs_q[p].port_cfg[`SPCR_CFG_BANK_EN];
            // With the clock stopped only the ring line can interrupt
            ctl_d[p].irq = ctl_d[p].active && (ctl_d[p].clk_en
                ? stat[p].uart_irq
                : (stat[p].ring_irq_en && !ring_n_q[p]));
            // Hard-wired base bits are forced to zero on the way out
            ctl_d[p].base_addr = {regs_q[p].base_high & `SPCR_WR_BASE_HIGH,
                regs_q[p].base_low & `SPCR_WR_BASE_LOW};
            // Remaining bytes pass through as stored
            ctl_d[p].irq_number = regs_q[p].irq_number;
            ctl_d[p].irq_type   = regs_q[p].irq_type;
            ctl_d[p].dma_rx     = regs_q[p].dma_rx;
            ctl_d[p].dma_tx     = regs_q[p].dma_tx;
        end
    end

    // ------------------------------------------------------------------
    // Registered control outputs
    // ------------------------------------------------------------------
    // Outputs lag the register write by one cycle; keeps pins glitch free
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            uart_a_ctl_out <= '0;
            uart_b_ctl_out <= '0;
        end
        else
        begin
            uart_a_ctl_out <= ctl_d[0];
            uart_b_ctl_out <= ctl_d[1];
        end
    end

    // ------------------------------------------------------------------
    // Infrared transmit
    // ------------------------------------------------------------------
    // Held low when port B is inactive, float bit has no say here
    always_ff @(posedge clock_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            infrared_transmit_out <= 1'b0;
        end
        else
        begin
            infrared_transmit_out <= ctl_d[1].clk_en && uart_b_ir_tx_in;
        end
    end

endmodule // spcr_regs

`default_nettype wire

// *** tb/spcr_regs_chk.sv ***
// Concurrent checks on the ports of the serial port configuration bank
`timescale 1ns/1ps
`default_nettype none
module spcr_regs_chk
    import spcr_pkg::*;
#(
    parameter int WB_ADR_W = 11
)
(
    input wire logic           clock_in,
    input wire logic           resetn_in,
    input wire logic           wb_cyc_in,
    input wire logic           wb_stb_in,
    input wire logic           wb_we_in,
    input wire logic [31:0]    wb_dat_out,
    input wire logic           wb_ack_out,
    input wire spcr_port_ctl_s uart_a_ctl_out,
    input wire spcr_port_ctl_s uart_b_ctl_out,
    input wire logic           infrared_transmit_out
);
    // ----------------------------------------------------------------
    // Bus sequencing and gating relations
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);

    // A taken request is answered by exactly one ack pulse
    sequence s_take;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_answer;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    a_ack_pulse: assert property (s_take |=> s_answer)
        else $error("ack not a single pulse after request");
    a_ack_cause: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
        else $error("ack without request");
    a_read_upper: assert property (wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_base_high_ro: assert property (uart_a_ctl_out.base_addr[15:11] == 5'h0 && uart_b_ctl_out.base_addr[15:11] == 5'h0)
        else $error("base address top bits not zero");
    a_base_align: assert property (uart_a_ctl_out.base_addr[2:0] == 3'h0 && uart_b_ctl_out.base_addr[2:0] == 3'h0)
        else $error("base address not aligned");
    a_low_power: assert property (uart_b_ctl_out.outputs_default == (uart_b_ctl_out.active && !uart_b_ctl_out.clk_en))
        else $error("default outputs mismatch");
    a_clk_gate: assert property (uart_a_ctl_out.clk_en |-> uart_a_ctl_out.active)
        else $error("clock runs on inactive port");
    a_runtime_gate: assert property (uart_b_ctl_out.runtime_en == uart_b_ctl_out.active)
        else $error("runtime access not tied to active");
    a_float_gate: assert property (uart_b_ctl_out.outputs_float |-> !uart_b_ctl_out.active)
        else $error("float while active");
    a_ir_inactive: assert property (!uart_b_ctl_out.active |-> !infrared_transmit_out)
        else $error("infrared driven while inactive");
    a_ext_gate: assert property (uart_b_ctl_out.ext_en |-> uart_b_ctl_out.active)
        else $error("extended access on inactive port");
endmodule // spcr_regs_chk

bind spcr_regs spcr_regs_chk #(.WB_ADR_W(WB_ADR_W)) u_chk (
    .clock_in(clock_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
    .wb_we_in(wb_we_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .uart_a_ctl_out(uart_a_ctl_out),
    .uart_b_ctl_out(uart_b_ctl_out), .infrared_transmit_out(infrared_transmit_out));
`default_nettype wire

// *** tb/spcr_regs_tb_top.sv ***
// Self-checking bench for the serial port configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"
module spcr_regs_tb_top
    import spcr_pkg::*;
;
    logic           clock_in  = 1'b0;
    logic           resetn_in = 1'b0;
    logic           wb_cyc    = 1'b0;
    logic           wb_stb    = 1'b0;
    logic           wb_we     = 1'b0;
    logic [10:0]    wb_adr    = 11'h0;
    logic [3:0]     wb_sel    = 4'h0;
    logic [31:0]    wb_dat    = 32'h0;
    logic [31:0]    wb_dat_out;
    logic           wb_ack_out;
    spcr_core_stat_s a_stat   = '0;
    spcr_core_stat_s b_stat   = '0;
    logic           ir_tx     = 1'b0;
    logic           ring_a_n  = 1'b1;
    logic           ring_b_n  = 1'b1;
    spcr_port_ctl_s a_ctl;
    spcr_port_ctl_s b_ctl;
    logic           ir_out;
    int             fails     = 0;
    int             n_checks  = 0;
    int             cycles    = 0;
    logic [7:0]     r;
    logic [7:0]     idx_t [8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hf0};
    logic [7:0]     rsta_t [8] = '{8'h00, 8'h03, 8'hf8, 8'h04, 8'h03, 8'h04, 8'h04, 8'h02};
    logic [7:0]     rstb_t [8] = '{8'h00, 8'h02, 8'hf8, 8'h03, 8'h03, 8'h04, 8'h04, 8'h02};

    spcr_regs dut (.clock_in(clock_in), .resetn_in(resetn_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb),
        .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out), .uart_a_stat_in(a_stat), .uart_b_stat_in(b_stat), .uart_b_ir_tx_in(ir_tx),
        .uart_a_ring_n_in(ring_a_n), .uart_b_ring_n_in(ring_b_n), .uart_a_ctl_out(a_ctl),
        .uart_b_ctl_out(b_ctl), .infrared_transmit_out(ir_out));

    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    always #5 clock_in = ~clock_in;

    // Whole run needs well under a thousand cycles; the ceiling only catches hangs
    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fails = fails + 1;
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic xfer(input logic we, input logic port, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clock_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {port, idx, 2'b00};
        wb_sel <= 4'h1;
        wb_dat <= {24'h0, d};
        // Only the bench ceiling ends this wait
        do
        begin
            @(posedge clock_in);
        end
        while (wb_ack_out !== 1'b1);
        r = wb_dat_out[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask

    task automatic wr(input logic port, input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, port, idx, d);
    endtask

    task automatic rd(input logic port, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, port, idx, 8'h0);
        chk({8'h0, r}, {8'h0, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clock_in);
        resetn_in <= 1'b1;
        settle(2);
        // Reset values of both register sets and derived controls
        for (int i = 0; i < 8; i++)
        begin
            rd(1'b0, idx_t[i], rsta_t[i]);
            rd(1'b1, idx_t[i], rstb_t[i]);
        end
        chk(a_ctl.base_addr, 16'h03f8);
        chk(b_ctl.base_addr, 16'h02f8);
        chk({15'h0, b_ctl.outputs_float}, 16'h0);
        $display("test reset values done");
        // Read-only bits, reserved bits and DMA selects on both ports
        for (int p = 0; p < 2; p++)
        begin
            wr(p[0], 8'h60, 8'hff);
            rd(p[0], 8'h60, 8'h07);
            wr(p[0], 8'h61, 8'hff);
            rd(p[0], 8'h61, 8'hf8);
            wr(p[0], 8'h71, 8'h00);
            rd(p[0], 8'h71, 8'h01);
            wr(p[0], 8'h71, 8'hff);
            rd(p[0], 8'h71, 8'h03);
            wr(p[0], 8'h70, 8'ha5);
            rd(p[0], 8'h70, 8'ha5);
            wr(p[0], 8'hf0, 8'h7c);
            rd(p[0], 8'hf0, 8'h00);
            wr(p[0], 8'hf0, 8'h02);
            wr(p[0], 8'h74, 8'h01);
            wr(p[0], 8'h75, 8'h02);
        end
        rd(1'b0, 8'h74, 8'h04);
        rd(1'b0, 8'h75, 8'h04);
        rd(1'b1, 8'h74, 8'h01);
        rd(1'b1, 8'h75, 8'h02);
        chk({b_ctl.dma_rx, b_ctl.dma_tx}, 16'h0102);
        chk({a_ctl.dma_rx, a_ctl.dma_tx}, 16'h0404);
        chk({a_ctl.irq_number, a_ctl.irq_type}, 16'ha503);
        chk(a_ctl.base_addr, 16'h07f8);
        wr(1'b0, 8'h40, 8'h55);
        rd(1'b0, 8'h40, 8'h00);
        $display("test access masks done");
        // Busy bit on port A follows the core's busy level
        a_stat.busy <= 1'b1;
        rd(1'b0, 8'hf0, 8'h06);
        a_stat.busy <= 1'b0;
        rd(1'b0, 8'hf0, 8'h02);
        $display("test busy done");
        // Global gating of activate on port A
        wr(1'b0, `SPCR_IDX_GLOBAL, 8'h00);
        wr(1'b0, 8'h30, 8'h01);
        settle(2);
        chk({15'h0, a_ctl.active}, 16'h0);
        wr(1'b0, `SPCR_IDX_GLOBAL, 8'h0d);
        settle(2);
        chk({15'h0, a_ctl.active}, 16'h1);
        // Port B active in normal power
        @(posedge clock_in);
        ir_tx <= 1'b1;
        b_stat.uart_irq <= 1'b1;
        wr(1'b1, 8'h30, 8'h01);
        settle(3);
        chk({12'h0, b_ctl.active, b_ctl.clk_en, b_ctl.runtime_en, b_ctl.outputs_default}, 16'he);
        chk({14'h0, ir_out, b_ctl.irq}, 16'h3);
        // Low power with bank switching enabled
        wr(1'b1, 8'hf0, 8'h80);
        settle(3);
        chk({11'h0, b_ctl.clk_en, b_ctl.outputs_default, b_ctl.ext_en, ir_out, b_ctl.irq}, 16'h0c);
        @(posedge clock_in);
        b_stat.ring_irq_en <= 1'b1;
        ring_b_n <= 1'b0;
        settle(6);
        chk({15'h0, b_ctl.irq}, 16'h1);
        @(posedge clock_in);
        ring_b_n <= 1'b1;
        rd(1'b1, 8'h70, 8'ha5);
        $display("test power modes done");
        // Deactivate with float enabled
        // Normal power restored, so only inactivity can hold the infrared line low
        wr(1'b1, 8'hf0, 8'h03);
        wr(1'b1, 8'h30, 8'h00);
        settle(3);
        chk({11'h0, b_ctl.active, b_ctl.outputs_float, b_ctl.runtime_en, b_ctl.ext_en, ir_out}, 16'h08);
        rd(1'b1, 8'h74, 8'h01);
        $display("test deactivate done");
        report_and_stop();
    end
endmodule // spcr_regs_tb_top
`default_nettype wire
